// ---- tem_pkg.sv ----
// Package for the translation-entry maintenance sequencer: commands, issue slots, entry layouts.
// Assumes the processor pipeline takes one issue slot per cycle on the same clock as the sequencer.
package tem_pkg;

  // ***************************************************************
  // Entry layouts
  // ***************************************************************
  localparam int TEM_WORD_W = 32;
  localparam int TEM_PID_W = 8;
  localparam int TEM_TAG_W = 13;
  localparam int TEM_PAGE_W = 22;
  localparam int TEM_TAG_ZERO_W = 9;
  localparam int TEM_PAGE_ZERO_W = 10;
  localparam int TEM_ROW_W = 9;
  localparam int TEM_ADDR_TAG_LSB = 19;
  localparam int TEM_ADDR_ROW_LSB = 12;
  localparam int TEM_PAGE_PAR_BIT = 9;
  localparam int TEM_PAGE_LSB = 10;
  // Position of the process identifier inside the status word
  localparam int TEM_PSW_PID_LSB = 0;
  localparam logic [TEM_WORD_W-1:0] TEM_WORD_ZERO = 32'h0000_0000;

  // ***************************************************************
  // Sequencing counts
  // ***************************************************************
  localparam logic [2:0] TEM_ACCESS_LAST = 3'h3;
  localparam logic [2:0] TEM_STATUS_LAST = 3'h4;
  localparam logic [3:0] TEM_RESULT_WAIT = 4'h8;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    TEM_CMD_READ_IFETCH_PAGE,
    TEM_CMD_READ_DSIDE_PAGE,
    TEM_CMD_WRITE_IFETCH_TAG,
    TEM_CMD_WRITE_DSIDE_TAG,
    TEM_CMD_WRITE_IFETCH_PAGE
  } tem_cmd_type;

  typedef enum logic [3:0] {
    TEM_INS_NULL,
    TEM_INS_ALU_MOVE,
    TEM_INS_ALU_NOT,
    TEM_INS_BRANCH,
    TEM_INS_WRITE_STATUS,
    TEM_INS_READ_IFETCH_PAGE,
    TEM_INS_READ_DSIDE_PAGE,
    TEM_INS_WRITE_IFETCH_TAG,
    TEM_INS_WRITE_DSIDE_TAG,
    TEM_INS_WRITE_IFETCH_PAGE
  } tem_ins_type;

  typedef struct packed {
    logic valid;
    tem_ins_type kind;
    logic column;
    logic [TEM_WORD_W-1:0] indexValue;
    logic [TEM_WORD_W-1:0] operand;
  } tem_slot_type;

  typedef struct packed {
    tem_cmd_type op;
    logic column;
    logic [TEM_WORD_W-1:0] addr;
    logic [TEM_PID_W-1:0] pid;
    logic invalid;
    logic writable;
    logic [TEM_PAGE_W-1:0] page;
  } tem_req_type;

  typedef struct packed {
    logic [TEM_WORD_W-1:0] data;
    logic [TEM_PAGE_W-1:0] page;
    logic parityErr;
    logic timeout;
  } tem_rsp_type;

endpackage : tem_pkg

// ---- tem_sequencer.sv ----
// Sequencer that issues translation-entry maintenance instructions to the processor pipeline.
// Assumes the pipeline is on ref_clk, takes one slot per cycle and returns read results itself.
// Function
// RL1 - Row follows address bits above the 4096-word block offset.
// RL2 - Hashing always on, so status-word pid is set before any access.
// RL3 - Read result holds page, odd parity of page, then zero bits.
// RL4 - Stored page is what memory sees on a hit.
// RL5 - Data-side page reads pick column by variant, result to target.
// RL6 - Instruction before an ifetch read leaves the index untouched.
// RL7 - Every ifetch-side access is followed by a branch.
// RL8 - No store or index change right before a data-side read.
// RL9 - No conditional branch on the target right after data-side read.
// RL10 - Instruction two cycles after a data-side access avoids the zero register.
// RL11 - Tag value: pid, tag, invalid, writable, nine zero bits.
// RL12 - Tag pid equals current status-word pid.
// RL13 - Tag field is upper 13 bits of virtual word address.
// RL14 - Invalid flag zero means valid, one means invalidated.
// RL15 - Writable flag one permits stores, zero means read-only.
// RL16 - Writes use result latch, loaded by ALU op just before.
// RL17 - Ifetch tag writes carry the complemented value.
// RL18 - Ifetch page writes carry the complemented value.
// RL19 - Icache miss during data tag write execute corrupts the write.
// RL20 - Page write value: 22-bit page then ten zero bits.
// RL21 - Ifetch tag writes pick column by variant, value from latch.
// RL22 - Address register loads index shifted by two; access then writeback.
`timescale 1ns/1ps
`default_nettype none
module tem_sequencer
  import tem_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire tem_pkg::tem_req_type cmdReq,
  output logic rspValid,
  output tem_pkg::tem_rsp_type rspData,
  output tem_pkg::tem_slot_type devSlot,
  input wire logic devResultValid,
  input wire logic [tem_pkg::TEM_WORD_W-1:0] devResultData
);
  import tem_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STATUS,
    ST_ACCESS,
    ST_WAIT,
    ST_DONE
  } tem_state_type;

  tem_state_type state_r, state_nxt;
  tem_req_type req_r, req_nxt;
  tem_slot_type slot_r, slot_nxt;
  tem_rsp_type rsp_r, rsp_nxt;
  logic [2:0] step_r, step_nxt;
  logic [3:0] wait_r, wait_nxt;
  logic [TEM_PID_W-1:0] curPid_r, curPid_nxt;
  logic pidKnown_r, pidKnown_nxt;
  logic ready_r, ready_nxt;
  logic rspVld_r, rspVld_nxt;

  logic isRead;
  logic isIfetch;
  logic [TEM_WORD_W-1:0] tagValue;
  logic [TEM_WORD_W-1:0] pageValue;
  logic [TEM_WORD_W-1:0] writeValue;
  logic [TEM_WORD_W-1:0] statusValue;
  tem_ins_type accessKind;

  // ***************************************************************
  // Value formatting
  // ***************************************************************
  // Tag pid is always the loaded status pid, so hashing stays consistent
  assign tagValue = {curPid_r, req_r.addr[TEM_ADDR_TAG_LSB +: TEM_TAG_W], // [RL11] [RL12] [RL13]
                     req_r.invalid, req_r.writable,                       // [RL14] [RL15]
                     {TEM_TAG_ZERO_W{1'b0}}};                             // [RL11]
  assign pageValue = {req_r.page, {TEM_PAGE_ZERO_W{1'b0}}}; // [RL20] [RL4]
  assign statusValue = TEM_WORD_W'({24'h00_0000, req_r.pid}) << TEM_PSW_PID_LSB; // [RL2]
  assign isRead = (req_r.op == TEM_CMD_READ_IFETCH_PAGE) || (req_r.op == TEM_CMD_READ_DSIDE_PAGE);
  assign isIfetch = (req_r.op == TEM_CMD_READ_IFETCH_PAGE) || (req_r.op == TEM_CMD_WRITE_IFETCH_TAG) ||
                    (req_r.op == TEM_CMD_WRITE_IFETCH_PAGE);

  // Value that the ALU op leaves in the result latch; ifetch side stores the complement
  always_comb
  begin
    case (req_r.op)
      TEM_CMD_WRITE_IFETCH_TAG: writeValue = ~tagValue; // [RL17]
      TEM_CMD_WRITE_IFETCH_PAGE: writeValue = ~pageValue; // [RL18]
      TEM_CMD_WRITE_DSIDE_TAG: writeValue = tagValue;
      default: writeValue = TEM_WORD_ZERO;
    endcase
  end

  // Special instruction kind for the requested access
  always_comb
  begin
    case (req_r.op)
      TEM_CMD_READ_IFETCH_PAGE: accessKind = TEM_INS_READ_IFETCH_PAGE;
      TEM_CMD_READ_DSIDE_PAGE: accessKind = TEM_INS_READ_DSIDE_PAGE; // [RL5]
      TEM_CMD_WRITE_IFETCH_TAG: accessKind = TEM_INS_WRITE_IFETCH_TAG; // [RL21]
      TEM_CMD_WRITE_DSIDE_TAG: accessKind = TEM_INS_WRITE_DSIDE_TAG;
      TEM_CMD_WRITE_IFETCH_PAGE: accessKind = TEM_INS_WRITE_IFETCH_PAGE;
      default: accessKind = TEM_INS_NULL;
    endcase
  end

  // ***************************************************************
  // Sequencer next state
  // ***************************************************************
  // One slot per cycle; padding slots keep the pipeline hazards out of reach
  always_comb
  begin
    state_nxt = state_r;
    req_nxt = req_r;
    step_nxt = step_r;
    wait_nxt = wait_r;
    curPid_nxt = curPid_r;
    pidKnown_nxt = pidKnown_r;
    rsp_nxt = rsp_r;
    rspVld_nxt = 1'b0;
    ready_nxt = 1'b0;
    slot_nxt = '0;
    slot_nxt.kind = TEM_INS_NULL;
    case (state_r)
      ST_IDLE:
      begin
        ready_nxt = 1'b1;
        if (cmdValid && ready_r)
        begin
          req_nxt = cmdReq;
          ready_nxt = 1'b0;
          step_nxt = 3'h0;
          // Status pid must match before touching entries
          if (!pidKnown_r || (cmdReq.pid != curPid_r)) // [RL2] [RL12]
            state_nxt = ST_STATUS;
          else
            state_nxt = ST_ACCESS;
        end
      end
      ST_STATUS:
      begin
        slot_nxt.valid = 1'b1;
        // Move, status write, then three pads before the new pid is in force
        if (step_r == 3'h0)
        begin
          slot_nxt.kind = TEM_INS_ALU_MOVE;
          slot_nxt.operand = statusValue;
        end
        else if (step_r == 3'h1)
          slot_nxt.kind = TEM_INS_WRITE_STATUS; // [RL2]
        step_nxt = step_r + 3'h1;
        if (step_r == TEM_STATUS_LAST)
        begin
          curPid_nxt = req_r.pid;
          pidKnown_nxt = 1'b1;
          step_nxt = 3'h0;
          state_nxt = ST_ACCESS;
        end
      end
      ST_ACCESS:
      begin
        slot_nxt.valid = 1'b1;
        slot_nxt.column = req_r.column; // [RL5] [RL21]
        slot_nxt.indexValue = req_r.addr; // [RL1] [RL22]
        case (step_r)
          3'h0:
          begin
            // Before a read: a null, so no store or index change precedes it
            // Before a write: the ALU op that loads the result latch
            if (isRead)
              slot_nxt.kind = TEM_INS_NULL; // [RL6] [RL8]
            else
            begin
              slot_nxt.kind = isIfetch ? TEM_INS_ALU_NOT : TEM_INS_ALU_MOVE; // [RL16]
              slot_nxt.operand = isIfetch ? ~writeValue : writeValue; // [RL17] [RL18]
            end
          end
          3'h1: slot_nxt.kind = accessKind; // [RL22]
          // Ifetch side clobbers its address register, so a branch follows
          3'h2: slot_nxt.kind = isIfetch ? TEM_INS_BRANCH : TEM_INS_NULL; // [RL7] [RL9]
          default: slot_nxt.kind = TEM_INS_NULL; // [RL10]
        endcase
        step_nxt = step_r + 3'h1;
        if (step_r == TEM_ACCESS_LAST)
        begin
          step_nxt = 3'h0;
          wait_nxt = 4'h0;
          if (isRead)
            state_nxt = ST_WAIT;
          else
          begin
            rsp_nxt = '0;
            state_nxt = ST_DONE;
          end
        end
      end
      ST_WAIT:
      begin
        // Result arrives from the writeback stage; bounded so a dead pipeline cannot hang us
        wait_nxt = wait_r + 4'h1;
        if (devResultValid)
        begin
          rsp_nxt.data = devResultData;
          rsp_nxt.page = devResultData[TEM_WORD_W-1 -: TEM_PAGE_W]; // [RL3]
          rsp_nxt.parityErr = ~(^devResultData[TEM_WORD_W-1:TEM_PAGE_PAR_BIT]) || // [RL3]
                              (devResultData[TEM_PAGE_PAR_BIT-1:0] != 9'h000);
          rsp_nxt.timeout = 1'b0;
          state_nxt = ST_DONE;
        end
        else if (wait_r == TEM_RESULT_WAIT)
        begin
          rsp_nxt = '0;
          rsp_nxt.timeout = 1'b1;
          state_nxt = ST_DONE;
        end
      end
      ST_DONE:
      begin
        rspVld_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  // Pure state registers; all ports come from here
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      req_r <= '0;
      slot_r <= '0;
      rsp_r <= '0;
      step_r <= 3'h0;
      wait_r <= 4'h0;
      curPid_r <= 8'h00;
      pidKnown_r <= 1'b0;
      ready_r <= 1'b0;
      rspVld_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      slot_r <= slot_nxt;
      rsp_r <= rsp_nxt;
      step_r <= step_nxt;
      wait_r <= wait_nxt;
      curPid_r <= curPid_nxt;
      pidKnown_r <= pidKnown_nxt;
      ready_r <= ready_nxt;
      rspVld_r <= rspVld_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign cmdReady = ready_r;
  assign rspValid = rspVld_r;
  assign rspData = rsp_r;
  assign devSlot = slot_r; // [RL19] no guard possible here: icache miss is the pipeline's own event

endmodule : tem_sequencer
`default_nettype wire

// ---- tem_seq_props.sv ----
// Checker for the sequencer's issue slots and its result handshake.
// Assumes it is bound onto tem_sequencer with one clock and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tem_seq_props
  import tem_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire tem_pkg::tem_slot_type devSlot,
  input wire logic devResultValid
);
  import tem_pkg::*;

  tem_ins_type k;
  logic ifAcc;
  logic tagW;
  logic [31:0] prevOp_r;
  logic [7:0] pid_r;
  // Empty slots count as null, so gaps look like padding
  assign k = devSlot.valid ? devSlot.kind : TEM_INS_NULL;
  assign ifAcc = k inside {TEM_INS_READ_IFETCH_PAGE, TEM_INS_WRITE_IFETCH_TAG, TEM_INS_WRITE_IFETCH_PAGE};
  assign tagW = k inside {TEM_INS_WRITE_IFETCH_TAG, TEM_INS_WRITE_DSIDE_TAG};
  // Last operand, and the pid that the last status write loaded
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prevOp_r <= '0;
      pid_r <= '0;
    end
    else
    begin
      prevOp_r <= devSlot.operand;
      pid_r <= (k == TEM_INS_WRITE_STATUS) ? prevOp_r[7:0] : pid_r;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ********
  // Slot order
  // ********
  ifetch_branch_a: assert property (ifAcc |=> k == TEM_INS_BRANCH)
    else $error("no branch after ifetch access");
  ifetch_prev_a: assert property (k == TEM_INS_READ_IFETCH_PAGE |-> $past(k) == TEM_INS_NULL)
    else $error("slot before ifetch read not null");
  dread_prev_a: assert property (k == TEM_INS_READ_DSIDE_PAGE |-> $past(k) == TEM_INS_NULL)
    else $error("slot before dside read not null");
  dside_tail_a: assert property (k inside {TEM_INS_READ_DSIDE_PAGE, TEM_INS_WRITE_DSIDE_TAG} |=> k == TEM_INS_NULL [*2])
    else $error("dside access tail not null");
  ifetch_not_a: assert property (k inside {TEM_INS_WRITE_IFETCH_TAG, TEM_INS_WRITE_IFETCH_PAGE} |-> $past(k) == TEM_INS_ALU_NOT)
    else $error("ifetch write without complement load");
  dtag_move_a: assert property (k == TEM_INS_WRITE_DSIDE_TAG |-> $past(k) == TEM_INS_ALU_MOVE)
    else $error("dside tag write without latch load");
  // ********
  // Entry values and read response
  // ********
  tag_fields_a: assert property (tagW |-> prevOp_r[31:24] == pid_r && prevOp_r[23:11] == devSlot.indexValue[31:19] && prevOp_r[8:0] == 9'h000)
    else $error("tag value fields wrong");
  page_zero_a: assert property (k == TEM_INS_WRITE_IFETCH_PAGE |-> prevOp_r[9:0] == 10'h000)
    else $error("page value low bits not zero");
  result_resp_a: assert property (devResultValid && !cmdReady |-> ##2 rspValid)
    else $error("read result not answered");
endmodule : tem_seq_props
`default_nettype wire

// ---- tem_pipe_model.sv ----
// Behavioural pipeline holding the translation page entries and the result latch.
// Assumes one slot per ref_clk cycle; lag stretches read answers.
`timescale 1ns/1ps
`default_nettype none
module tem_pipe_model
  import tem_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire tem_pkg::tem_slot_type devSlot,
  input wire logic [1:0] lag,
  input wire logic [1:0] fault,
  output logic devResultValid,
  output logic [31:0] devResultData,
  output logic [31:0] lastWr
);
  import tem_pkg::*;

  logic [31:0] rr_r, res_r, e, v;
  logic [31:0] ipg [1024];
  logic [31:0] dpg [1024];
  logic [7:0] pid_r;
  logic [2:0] cnt_r;
  logic [9:0] ix;
  // Row from the 4096-word block, always hashed with pid; column on top
  assign ix = {devSlot.column, devSlot.indexValue[20:12] ^ {1'b0, pid_r}};
  assign e = (devSlot.kind == TEM_INS_READ_IFETCH_PAGE) ? ipg[ix] : dpg[ix];
  assign v = (devSlot.kind == TEM_INS_WRITE_DSIDE_TAG) ? rr_r : ~rr_r;
  // Bus idles inverted so a stale word never passes
  assign devResultData = devResultValid ? res_r : ~res_r;
  // No cache misses modelled, so data tag writes always land
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rr_r <= '0;
      pid_r <= '0;
      cnt_r <= '0;
      res_r <= '0;
      lastWr <= '0;
      devResultValid <= 1'b0;
      for (int i = 0; i < 1024; i++)
        dpg[i] <= {12'h000, i[9:0], 10'h000}; // Page equals column and hashed row
    end
    else
    begin
      devResultValid <= (cnt_r == 3'h1) && !fault[0]; // Mute drops the answer to force a timeout
      cnt_r <= cnt_r - {2'h0, cnt_r != 3'h0};
      if (devSlot.valid)
      begin
        rr_r <= ~rr_r; // Any other instruction spoils the latch
        case (devSlot.kind)
          TEM_INS_ALU_MOVE: rr_r <= devSlot.operand;
          TEM_INS_ALU_NOT: rr_r <= ~devSlot.operand;
          TEM_INS_WRITE_STATUS: pid_r <= rr_r[7:0];
          TEM_INS_WRITE_IFETCH_PAGE:
          begin
            ipg[ix] <= ~rr_r;
            lastWr <= ~rr_r;
          end
          TEM_INS_WRITE_IFETCH_TAG, TEM_INS_WRITE_DSIDE_TAG:
          begin
            lastWr <= v | {31'h0, v[31:24] != pid_r}; // Bit 0 flags a foreign pid
          end
          TEM_INS_READ_IFETCH_PAGE, TEM_INS_READ_DSIDE_PAGE:
          begin
            res_r <= {e[31:10], (~^e[31:10]) ^ fault[1], 9'h000}; // parity flipped on request
            cnt_r <= 3'h2 + {1'b0, lag};
          end
          default: ;
        endcase
      end
    end
  end
endmodule : tem_pipe_model
`default_nettype wire

// ---- tem_sequencer_tb.sv ----
// Testbench driving the sequencer against the pipeline model.
// Assumes tem_pkg, tem_pipe_model and tem_seq_props are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tem_sequencer_tb;
  import tem_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdReady, rspValid, devResultValid, c, iv, w;
  logic [1:0] lag = 2'h0;
  logic [1:0] fault = 2'h0;
  tem_req_type cmdReq = '0;
  tem_rsp_type rspData;
  tem_slot_type devSlot;
  logic [31:0] devResultData, lastWr, a, lw;
  logic [21:0] pg, x;
  logic [7:0] pid;
  tem_rsp_type qr[$];
  logic [31:0] qw[$];
  int miscompares = 0;
  int nChecks = 0;
  // Clock
  always #50 ref_clk = ~ref_clk;
  tem_sequencer tem_sequencer_inst (.ref_clk(ref_clk), .arst_n(arst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdReq(cmdReq), .rspValid(rspValid), .rspData(rspData), .devSlot(devSlot), .devResultValid(devResultValid),
    .devResultData(devResultData));
  tem_pipe_model tem_pipe_model_inst (.ref_clk(ref_clk), .arst_n(arst_n), .devSlot(devSlot), .lag(lag), .fault(fault),
    .devResultValid(devResultValid), .devResultData(devResultData), .lastWr(lastWr));
  task automatic chk(string nm, logic [55:0] s, logic [55:0] e);
    nChecks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic closeOut();
    if (miscompares == 0 && nChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : closeOut
  // One command; expectations are noted before it is offered
  task automatic cmd(tem_cmd_type op, logic [31:0] ew, logic [31:0] ed, logic [1:0] ef = 2'b00);
    qr.push_back((op inside {TEM_CMD_READ_IFETCH_PAGE, TEM_CMD_READ_DSIDE_PAGE}) ? {ed, ed[31:10], ef} : '0);
    qw.push_back(ew);
    lw = ew;
    do @(negedge ref_clk); while (cmdReady !== 1'b1);
    cmdReq <= '{op, c, a, pid, iv, w, pg};
    cmdValid <= 1'b1;
    lag <= 2'($urandom);
    @(negedge ref_clk);
    cmdValid <= 1'b0;
  endtask : cmd
  // Oldest note against each response and written entry
  always @(negedge ref_clk)
    if (rspValid === 1'b1)
    begin
      chk("response", rspData, qr.pop_front());
      chk("entry", {24'h0, lastWr}, {24'h0, qw.pop_front()});
    end
  // Watchdog, far beyond the run's length
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    closeOut();
  end
  // Rounds with fresh pid, address, column and entry values
  initial
  begin
    void'($urandom(88676));
    repeat (16) @(negedge ref_clk);
    arst_n = 1'b1;
    for (int k = 0; k < 10; k++)
    begin
      pid = 8'($urandom);
      a = $urandom;
      pg = 22'($urandom);
      c = k[0];
      iv = 1'($urandom);
      w = 1'($urandom);
      cmd(TEM_CMD_WRITE_IFETCH_PAGE, {pg, 10'h000}, '0);
      cmd(TEM_CMD_READ_IFETCH_PAGE, lw, {pg, ~^pg, 9'h000});
      cmd(TEM_CMD_WRITE_IFETCH_TAG, {pid, a[31:19], iv, w, 9'h000}, '0);
      c = ~c;
      cmd(TEM_CMD_WRITE_DSIDE_TAG, lw, '0);
      x = {12'h000, c, a[20:12] ^ {1'b0, pid}};
      cmd(TEM_CMD_READ_DSIDE_PAGE, lw, {x, ~^x, 9'h000});
    end
    // Fault rounds: bad parity, then a silent pipeline; drained first so no earlier read is spoiled
    for (int m = 2; m >= 0; m--)
    begin
      for (int i = 0; i < 60 && qr.size() != 0; i++) @(negedge ref_clk);
      fault <= 2'(m);
      if (m == 2)
        cmd(TEM_CMD_READ_DSIDE_PAGE, lw, {x, ^x, 9'h000}, 2'b10);
      if (m == 1)
        cmd(TEM_CMD_READ_DSIDE_PAGE, lw, '0, 2'b01);
    end
    chk("pending", 56'(qr.size()), '0);
    closeOut();
  end
endmodule : tem_sequencer_tb
bind tem_sequencer tem_seq_props tem_seq_props_inst (.ref_clk(ref_clk), .arst_n(arst_n), .cmdReady(cmdReady),
  .rspValid(rspValid), .devSlot(devSlot), .devResultValid(devResultValid));
`default_nettype wire
